/* File: eesf_regs.svh */
// Register offsets, field positions, reset values and exception codes of the status fields
`ifndef EESF_REGS_SVH
`define EESF_REGS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define EESF_OFS_PSW 12'h000
`define EESF_OFS_EXEC 12'h004
`define EESF_OFS_EXCN 12'h008
`define EESF_OFS_CTRL 12'h00c
`define EESF_OFS_STAT 12'h010

// ************************************************************
// Field positions in the status word and in the control and status registers
// ************************************************************
`define EESF_TBIT_POS 24
`define EESF_SHH_HI 15
`define EESF_SHH_LO 10
`define EESF_SHL_HI 26
`define EESF_SHL_LO 25
`define EESF_EXC_HI 5
`define EESF_EXC_LO 0
`define EESF_CTRL_LOCK_POS 0
`define EESF_STAT_LOCK_POS 0
`define EESF_STAT_MODE_LO 1

// ************************************************************
// Reset values
// ************************************************************
`define EESF_TBIT_RST 1'b1
`define EESF_EXC_RST 6'h00
`define EESF_SH_RST 8'h00
`define EESF_CTRL_RST 1'b0

// ************************************************************
// Active exception codes
// ************************************************************
`define EESF_EXC_THREAD 6'h00
`define EESF_EXC_NMI 6'h02
`define EESF_EXC_HARD 6'h03
`define EESF_EXC_MEM 6'h04
`define EESF_EXC_BUS 6'h05
`define EESF_EXC_USAGE 6'h06
`define EESF_EXC_SVC 6'h0b
`define EESF_EXC_PSV 6'h0e
`define EESF_EXC_TICK 6'h0f
`define EESF_EXC_IRQ0 6'h10
`define EESF_EXC_IRQ_LAST 6'h3b

`endif

/* File: eesf_pkg.sv */
// Types shared by the execution and exception status field logic
package eesf_pkg;

   // ************************************************************
   // Content of the shared continuation / conditional field
   // ************************************************************
   typedef enum logic [1:0] {
      EESF_SH_NONE = 2'b00,
      EESF_SH_CONT = 2'b01,
      EESF_SH_COND = 2'b10
   } eesf_mode_e;

   // ************************************************************
   // Exception entry request from the sequencer
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic vec_lsb;
      logic [5:0] num;
   } eesf_entry_s;

   // ************************************************************
   // Exception return request with the stacked status word
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [31:0] word;
   } eesf_return_s;

   // ************************************************************
   // Conditional block start from the decoder
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [3:0] first_cond;
      logic [3:0] mask;
   } eesf_cond_s;

endpackage

/* File: eesf_exc_check.sv */
// Checks that an active exception code is one that may be reported
`timescale 1ns/10ps
`include "eesf_regs.svh"

module eesf_exc_check #(
   parameter int CODE_W = 6
) (
   // Code under test
   input wire logic [CODE_W-1:0] code_i,
   // Code is a defined, non-reserved number
   output logic ok_o
);

   // Accept only defined codes; reserved numbers never pass
   always_comb begin
      case (code_i)
         `EESF_EXC_THREAD,
         `EESF_EXC_NMI,
         `EESF_EXC_HARD,
         `EESF_EXC_MEM,
         `EESF_EXC_BUS,
         `EESF_EXC_USAGE,
         `EESF_EXC_SVC,
         `EESF_EXC_PSV,
         `EESF_EXC_TICK: begin
            ok_o = 1'b1;
         end
         default: begin
            // External vectors form one contiguous range
            ok_o = (code_i >= `EESF_EXC_IRQ0) && (code_i <= `EESF_EXC_IRQ_LAST);
         end
      endcase
   end

endmodule

/* File: eesf_status.sv */
// Execution state, shared continuation field and active exception number with APB access
//
// How it works
// - Read-only state bit 24, resets to one
// - Exchange branches load state bit from target
// - Exception return restores state bit from stack
// - Exception entry loads state bit from vector
// - Executing with state clear faults or locks up
// - Bits 23:16 and 9:6 read zero
// - Shared field holds continuation or conditional state
// - Interrupted transfer records next register in 15:12
// - Return resumes transfer at recorded register
// - Continuation state keeps bits 11:10 zero
// - Track conditional block of up to four
// - Bits 5:0 hold active exception, reset zero
// - Fixed codes for system exceptions
// - External vectors 0x10 up to 0x3B
// - Reserved exception codes never reported
// - Exception number only in word or number view
// - Continuation state keeps bits 26:25 zero
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "eesf_regs.svh"

module eesf_status #(
   parameter int ADDR_W = 12
) (
   // Clock, reset and freeze
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Pipeline: executing instruction and exchange branches
   input wire logic instr_exec_i,
   input wire logic exch_branch_i,
   input wire logic target_lsb_i,
   // Exception sequencer
   input wire eesf_pkg::eesf_entry_s entry_i,
   input wire eesf_pkg::eesf_return_s return_i,
   // Multi-register transfers
   input wire logic xfer_suspend_i,
   input wire logic [3:0] xfer_next_reg_i,
   input wire logic xfer_done_i,
   // Conditional block
   input wire eesf_pkg::eesf_cond_s cond_start_i,
   input wire logic cond_advance_i,
   // State towards the pipeline
   output logic state_bit_o,
   output logic cond_active_o,
   output logic [3:0] cond_code_o,
   output logic resume_valid_o,
   output logic [3:0] resume_reg_o,
   output logic [5:0] active_exc_o,
   output logic invalid_state_fault_o,
   output logic lockup_o
);

   import eesf_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic tbit_r; // Instruction-set state bit
   logic tbit_nxt;
   logic [7:0] sh_r; // Shared field, high six bits then low two
   logic [7:0] sh_nxt;
   eesf_mode_e mode_r; // What the shared field holds
   eesf_mode_e mode_nxt;
   logic [5:0] exc_r; // Active exception number
   logic [5:0] exc_nxt;
   logic resume_r; // Resume pulse towards the transfer unit
   logic resume_nxt;
   logic [3:0] resume_reg_r; // Register where the transfer resumes
   logic [3:0] resume_reg_nxt;
   logic fault_r; // Invalid-state fault pulse
   logic fault_nxt;
   logic lock_r; // Lockup level, left only by reset
   logic lock_nxt;
   logic ctrl_lock_r; // Software choice: lockup instead of fault
   logic ctrl_lock_nxt;
   logic [31:0] rdata_r; // Read data captured in the setup cycle
   logic [31:0] rdata_nxt;
   logic err_r; // Error answer captured in the setup cycle
   logic err_nxt;
   logic held_r; // Read data are ready for the access phase
   logic held_nxt;
   logic entry_ok; // Entry code is a valid number
   logic ret_ok; // Stacked code is a valid number
   logic [7:0] stk_sh; // Shared field taken from the stacked word
   logic setup; // APB setup cycle
   logic wr_done; // APB write completes this cycle
   logic [31:0] psw_word; // Full status word image
   logic [31:0] exec_word; // Execution view image
   logic [31:0] excn_word; // Exception number view image

   // ************************************************************
   // Exception code checkers
   // ************************************************************
   // Entry number checked before it may reach the field
   eesf_exc_check #(
      .CODE_W(6)
   ) u_entry_check (
      .code_i(entry_i.num),
      .ok_o(entry_ok)
   );

   // Stacked number checked before it is restored
   eesf_exc_check #(
      .CODE_W(6)
   ) u_ret_check (
      .code_i(return_i.word[`EESF_EXC_HI:`EESF_EXC_LO]),
      .ok_o(ret_ok)
   );

   // ************************************************************
   // Register images
   // ************************************************************
   // Reserved bits and flags out of this block stay zero
   always_comb begin
      exec_word = 32'h0000_0000;
      exec_word[`EESF_TBIT_POS] = tbit_r;
      exec_word[`EESF_SHH_HI:`EESF_SHH_LO] = sh_r[7:2];
      exec_word[`EESF_SHL_HI:`EESF_SHL_LO] = sh_r[1:0];
      excn_word = 32'h0000_0000;
      excn_word[`EESF_EXC_HI:`EESF_EXC_LO] = exc_r;
      psw_word = exec_word | excn_word;
   end

   // Stacked shared field reassembled from its two pieces
   assign stk_sh = {return_i.word[`EESF_SHH_HI:`EESF_SHH_LO],
                    return_i.word[`EESF_SHL_HI:`EESF_SHL_LO]};

   // ************************************************************
   // Execution state and exception number
   // ************************************************************
   // Next values of state bit, shared field and exception number
   always_comb begin
      tbit_nxt = tbit_r;
      sh_nxt = sh_r;
      mode_nxt = mode_r;
      exc_nxt = exc_r;
      resume_nxt = 1'b0;
      resume_reg_nxt = resume_reg_r;
      if (entry_i.valid) begin
         // Entry takes the state bit from the vector entry
         tbit_nxt = entry_i.vec_lsb;
         if (entry_ok) begin
            exc_nxt = entry_i.num;
         end
         // An interrupted transfer leaves its continuation point
         if (xfer_suspend_i) begin
            sh_nxt = {xfer_next_reg_i, 4'h0};
            mode_nxt = EESF_SH_CONT;
         end else begin
            sh_nxt = `EESF_SH_RST;
            mode_nxt = EESF_SH_NONE;
         end
      end else if (return_i.valid) begin
         // Return restores the interrupted context
         tbit_nxt = return_i.word[`EESF_TBIT_POS];
         if (ret_ok) begin
            exc_nxt = return_i.word[`EESF_EXC_HI:`EESF_EXC_LO];
         end
         if (stk_sh[3:0] != 4'h0) begin
            // Non-zero mask: a conditional block was open
            sh_nxt = stk_sh;
            mode_nxt = EESF_SH_COND;
         end else if (stk_sh != `EESF_SH_RST) begin
            // Continuation point: resume the transfer there
            sh_nxt = {stk_sh[7:4], 4'h0};
            mode_nxt = EESF_SH_CONT;
            resume_nxt = 1'b1;
            resume_reg_nxt = stk_sh[7:4];
         end else begin
            sh_nxt = `EESF_SH_RST;
            mode_nxt = EESF_SH_NONE;
         end
      end else begin
         // Exchange branch takes the state bit from the target
         if (exch_branch_i) begin
            tbit_nxt = target_lsb_i;
         end
         case (mode_r)
            EESF_SH_CONT: begin
               // Resumed transfer finished: field empties
               if (xfer_done_i) begin
                  sh_nxt = `EESF_SH_RST;
                  mode_nxt = EESF_SH_NONE;
               end
            end
            EESF_SH_COND: begin
               // Each completed instruction shifts the mask
               if (cond_advance_i) begin
                  if (sh_r[2:0] == 3'h0) begin
                     sh_nxt = `EESF_SH_RST;
                     mode_nxt = EESF_SH_NONE;
                  end else begin
                     sh_nxt = {sh_r[7:5], sh_r[3:0], 1'b0};
                  end
               end
            end
            EESF_SH_NONE: begin
               // A block start opens up to four conditional slots
               if (cond_start_i.valid && (cond_start_i.mask != 4'h0)) begin
                  sh_nxt = {cond_start_i.first_cond, cond_start_i.mask};
                  mode_nxt = EESF_SH_COND;
               end
            end
            default: begin
               sh_nxt = `EESF_SH_RST;
               mode_nxt = EESF_SH_NONE;
            end
         endcase
      end
   end

   // Register the execution state; software cannot reach it
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tbit_r <= `EESF_TBIT_RST;
         sh_r <= `EESF_SH_RST;
         mode_r <= EESF_SH_NONE;
         exc_r <= `EESF_EXC_RST;
         resume_r <= 1'b0;
         resume_reg_r <= 4'h0;
      end else if (ce_i) begin
         tbit_r <= tbit_nxt;
         sh_r <= sh_nxt;
         mode_r <= mode_nxt;
         exc_r <= exc_nxt;
         resume_r <= resume_nxt;
         resume_reg_r <= resume_reg_nxt;
      end
   end

   // ************************************************************
   // Invalid state handling
   // ************************************************************
   // Executing with the state bit clear faults, or locks up when chosen
   // or when the hard fault handler itself is running
   always_comb begin
      fault_nxt = 1'b0;
      lock_nxt = lock_r;
      if (instr_exec_i && !tbit_r && !lock_r) begin
         if (ctrl_lock_r || (exc_r == `EESF_EXC_HARD)) begin
            lock_nxt = 1'b1;
         end else begin
            fault_nxt = 1'b1;
         end
      end
   end

   // Register the fault pulse and the lockup level
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_r <= 1'b0;
         lock_r <= 1'b0;
      end else if (ce_i) begin
         fault_r <= fault_nxt;
         lock_r <= lock_nxt;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   assign setup = psel_i && !penable_i;
   assign wr_done = psel_i && penable_i && pready_o && pwrite_i;

   // Decode in the setup cycle; answer in the first access cycle
   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      held_nxt = held_r;
      ctrl_lock_nxt = ctrl_lock_r;
      if (setup) begin
         held_nxt = 1'b1;
         err_nxt = 1'b0;
         case (paddr_i)
            `EESF_OFS_PSW: begin
               rdata_nxt = psw_word;
            end
            `EESF_OFS_EXEC: begin
               rdata_nxt = exec_word;
            end
            `EESF_OFS_EXCN: begin
               rdata_nxt = excn_word;
            end
            `EESF_OFS_CTRL: begin
               rdata_nxt = {31'h0000_0000, ctrl_lock_r};
            end
            `EESF_OFS_STAT: begin
               rdata_nxt = {29'h0000_0000, mode_r, lock_r};
            end
            default: begin
               // Unmapped: zero data and an error answer
               rdata_nxt = 32'h0000_0000;
               err_nxt = 1'b1;
            end
         endcase
      end else if (psel_i && penable_i && held_r) begin
         held_nxt = 1'b0;
      end
      // Only the control word takes write data; status views ignore it
      if (wr_done && (paddr_i == `EESF_OFS_CTRL)) begin
         ctrl_lock_nxt = pwdata_i[`EESF_CTRL_LOCK_POS];
      end
   end

   // Register bus-side state
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
         held_r <= 1'b0;
         ctrl_lock_r <= `EESF_CTRL_RST;
      end else if (ce_i) begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
         held_r <= held_nxt;
         ctrl_lock_r <= ctrl_lock_nxt;
      end
   end

   // Ready only while running, so a frozen block stalls the bus
   assign pready_o = psel_i && penable_i && held_r && ce_i;
   assign prdata_o = rdata_r;
   assign pslverr_o = pready_o && err_r;

   // ************************************************************
   // Outputs towards the pipeline
   // ************************************************************
   assign state_bit_o = tbit_r;
   assign cond_active_o = (mode_r == EESF_SH_COND);
   assign cond_code_o = sh_r[7:4];
   assign resume_valid_o = resume_r;
   assign resume_reg_o = resume_reg_r;
   assign active_exc_o = exc_r;
   assign invalid_state_fault_o = fault_r;
   assign lockup_o = lock_r;

endmodule

/* File: eesf_status_asserts.sv */
// Concurrent checks on the ports of the status field block
`timescale 1ns/10ps
module eesf_status_asserts #(
   parameter int ADDR_W = 12
) (
   // Clock, reset and bus
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic pready_o,
   // Pipeline and sequencer
   input wire logic instr_exec_i,
   input wire logic exch_branch_i,
   input wire logic target_lsb_i,
   input wire eesf_pkg::eesf_entry_s entry_i,
   input wire eesf_pkg::eesf_return_s return_i,
   // Observed state
   input wire logic state_bit_o,
   input wire logic resume_valid_o,
   input wire logic [3:0] resume_reg_o,
   input wire logic [5:0] active_exc_o,
   input wire logic invalid_state_fault_o,
   input wire logic lockup_o
);
   import eesf_pkg::*;
   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic rsv; // Entry number is a reserved code
   logic quiet; // No entry, return or exchange branch this cycle
   assign rsv = entry_i.num inside {6'h01, [6'h07:6'h0a], 6'h0c, 6'h0d, [6'h3c:6'h3f]};
   assign quiet = !entry_i.valid && !return_i.valid && !exch_branch_i;
   a_exch_bit: assert property (
      ce_i && exch_branch_i && !entry_i.valid && !return_i.valid
      |=> state_bit_o == $past(target_lsb_i)) else $error("branch bit wrong");
   a_return_bit: assert property (
      ce_i && return_i.valid && !entry_i.valid
      |=> state_bit_o == $past(return_i.word[24])) else $error("return bit wrong");
   a_entry_bit: assert property (
      ce_i && entry_i.valid |=> state_bit_o == $past(entry_i.vec_lsb)) else $error("vector bit");
   a_fault_clear: assert property (
      ce_i && instr_exec_i && !state_bit_o && !lockup_o && quiet
      |=> invalid_state_fault_o || lockup_o) else $error("no fault");
   a_lock_hold: assert property (
      lockup_o |=> lockup_o ##1 lockup_o) else $error("lockup dropped");
   a_entry_num: assert property (
      ce_i && entry_i.valid && !rsv |=> active_exc_o == $past(entry_i.num)) else $error("exc num");
   a_rsv_kept: assert property (
      ce_i && entry_i.valid && rsv |=> $stable(active_exc_o)) else $error("reserved taken");
   a_resume_reg: assert property (
      ce_i && return_i.valid && !entry_i.valid && return_i.word[26:25] == 2'b00
      && return_i.word[11:10] == 2'b00 && return_i.word[15:12] != 4'h0
      |=> resume_valid_o && resume_reg_o == $past(return_i.word[15:12])
      ##1 !resume_valid_o) else $error("resume wrong");
   a_ro_write: assert property (
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == '0 && quiet
      |=> $stable(state_bit_o) && $stable(active_exc_o)) else $error("write took effect");
endmodule
bind eesf_status eesf_status_asserts #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_i, .arst_n_i, .ce_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .instr_exec_i, .exch_branch_i,
   .target_lsb_i, .entry_i, .return_i, .state_bit_o, .resume_valid_o, .resume_reg_o,
   .active_exc_o, .invalid_state_fault_o, .lockup_o);

/* File: eesf_pipe_model.sv */
// Behavioural pipeline and exception sequencer feeding the status fields
`timescale 1ns/10ps
module eesf_pipe_model (
   // Clock
   input wire logic clk_i,
   // Events towards the status block
   output logic exec_o,
   output logic exch_o,
   output logic lsb_o,
   output eesf_pkg::eesf_entry_s entry_o,
   output eesf_pkg::eesf_return_s ret_o,
   output logic susp_o,
   output logic [3:0] nreg_o,
   output logic done_o,
   output eesf_pkg::eesf_cond_s cond_o,
   output logic adv_o
);
   import eesf_pkg::*;
   // Idle at time zero
   initial begin
      {exec_o, exch_o, lsb_o, susp_o, done_o, adv_o} = '0;
      entry_o = '0;
      ret_o = '0;
      nreg_o = '0;
      cond_o = '0;
   end
   // Exception entry; data fields turn to garbage afterwards
   task automatic entry(input logic [5:0] n, input logic v, input logic s, input logic [3:0] r);
      @(posedge clk_i);
      entry_o <= '{1'b1, v, n};
      susp_o <= s;
      nreg_o <= r;
      @(posedge clk_i);
      entry_o <= '{1'b0, ~v, ~n};
      susp_o <= 1'b0;
      nreg_o <= ~r;
   endtask
   // Exception return with stacked word
   task automatic ret(input logic [31:0] w);
      @(posedge clk_i);
      ret_o <= '{1'b1, w};
      @(posedge clk_i);
      ret_o <= '{1'b0, ~w};
   endtask
   // Exchange branch with target bit
   task automatic exch(input logic l);
      @(posedge clk_i);
      exch_o <= 1'b1;
      lsb_o <= l;
      @(posedge clk_i);
      exch_o <= 1'b0;
      lsb_o <= ~l;
   endtask
   // Conditional block start
   task automatic cond(input logic [3:0] c, input logic [3:0] m);
      @(posedge clk_i);
      cond_o <= '{1'b1, c, m};
      @(posedge clk_i);
      cond_o <= '{1'b0, ~c, ~m};
   endtask
   // Single pulse: 0 execute, 1 advance, 2 transfer done
   task automatic pulse(input int k);
      @(posedge clk_i);
      exec_o <= (k == 0);
      adv_o <= (k == 1);
      done_o <= (k == 2);
      @(posedge clk_i);
      {exec_o, adv_o, done_o} <= 3'b000;
   endtask
endmodule

/* File: eesf_status_tb.sv */
// Self-checking bench for the status field block
`timescale 1ns/10ps
`include "eesf_regs.svh"
module eesf_status_tb;
   import eesf_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   logic ref_clk_i = 1'b0;
   logic arst_n_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic instr_exec_i, exch_branch_i, target_lsb_i, xfer_suspend_i, xfer_done_i, er;
   logic cond_advance_i, state_bit_o, cond_active_o, resume_valid_o, invalid_state_fault_o;
   logic lockup_o;
   logic [3:0] xfer_next_reg_i, cond_code_o, resume_reg_o;
   logic [5:0] active_exc_o;
   eesf_entry_s entry_i;
   eesf_return_s return_i;
   eesf_cond_s cond_start_i;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // Entry number beside the number it should report
   logic [11:0] rows [19] = '{{6'h02, 6'h02}, {6'h03, 6'h03}, {6'h04, 6'h04}, {6'h05, 6'h05},
      {6'h06, 6'h06}, {6'h0b, 6'h0b}, {6'h0e, 6'h0e}, {6'h0f, 6'h0f}, {6'h10, 6'h10},
      {6'h11, 6'h11}, {6'h3b, 6'h3b}, {6'h00, 6'h00}, {6'h01, 6'h00}, {6'h07, 6'h00},
      {6'h0a, 6'h00}, {6'h0c, 6'h00}, {6'h0d, 6'h00}, {6'h3c, 6'h00}, {6'h3f, 6'h00}};
   always #20 ref_clk_i = ~ref_clk_i;
   eesf_status #(.ADDR_W(12)) u_dut (.ref_clk_i, .arst_n_i, .ce_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .instr_exec_i,
      .exch_branch_i, .target_lsb_i, .entry_i, .return_i, .xfer_suspend_i, .xfer_next_reg_i,
      .xfer_done_i, .cond_start_i, .cond_advance_i, .state_bit_o, .cond_active_o,
      .cond_code_o, .resume_valid_o, .resume_reg_o, .active_exc_o, .invalid_state_fault_o,
      .lockup_o);
   eesf_pipe_model u_pipe (.clk_i(ref_clk_i), .exec_o(instr_exec_i), .exch_o(exch_branch_i),
      .lsb_o(target_lsb_i), .entry_o(entry_i), .ret_o(return_i), .susp_o(xfer_suspend_i),
      .nreg_o(xfer_next_reg_i), .done_o(xfer_done_i), .cond_o(cond_start_i),
      .adv_o(cond_advance_i));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1);
      chk(n, 1, "wait states");
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Cut a hang short
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      {arst_n_i, psel_i, penable_i, pwrite_i} = '0;
      ce_i = 1'b1;
      paddr_i = '0;
      pwdata_i = '0;
      repeat (2) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      foreach (rows[i]) begin
         u_pipe.entry(rows[i][11:6], i[0], 1'b0, 4'h0);
         apb(1'b0, `EESF_OFS_EXCN, 32'h0);
         chk(rd, {26'h0, rows[i][5:0]}, "exc number");
         chk(state_bit_o, i[0], "vector bit");
      end
      $display("table done");
      arst_n_i <= 1'b0;
      @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(negedge ref_clk_i);
      chk(state_bit_o, 1'b1, "reset bit");
      apb(1'b0, `EESF_OFS_PSW, 32'h0);
      chk(rd, 32'h0100_0000, "reset word");
      apb(1'b1, `EESF_OFS_PSW, 32'hffff_ffff);
      apb(1'b0, `EESF_OFS_PSW, 32'h0);
      chk(rd, 32'h0100_0000, "write ignored");
      apb(1'b0, 12'h020, 32'h0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped");
      $display("reset and access done");
      u_pipe.entry(6'h12, 1'b1, 1'b1, 4'h5);
      u_pipe.cond(4'ha, 4'h8);
      apb(1'b0, `EESF_OFS_PSW, 32'h0);
      chk(rd, 32'h0100_5012, "suspended word");
      apb(1'b0, `EESF_OFS_EXEC, 32'h0);
      chk(rd, 32'h0100_5000, "exec view");
      u_pipe.ret(32'h0100_5000);
      @(negedge ref_clk_i);
      chk({resume_valid_o, resume_reg_o}, 5'h15, "resume");
      @(negedge ref_clk_i);
      chk(resume_valid_o, 1'b0, "resume pulse");
      u_pipe.pulse(2);
      u_pipe.cond(4'ha, 4'h0);
      @(negedge ref_clk_i);
      chk(cond_active_o, 1'b0, "empty mask");
      u_pipe.cond(4'ha, 4'h4);
      apb(1'b0, `EESF_OFS_PSW, 32'h0);
      chk(rd, 32'h0100_a400, "cond word");
      u_pipe.pulse(1);
      @(negedge ref_clk_i);
      chk({cond_active_o, cond_code_o}, 5'h1a, "advance");
      u_pipe.pulse(1);
      @(negedge ref_clk_i);
      chk(cond_active_o, 1'b0, "block end");
      $display("transfer and block done");
      u_pipe.ret(32'h0);
      @(negedge ref_clk_i);
      chk(state_bit_o, 1'b0, "stacked bit");
      u_pipe.pulse(0);
      @(negedge ref_clk_i);
      chk({invalid_state_fault_o, lockup_o}, 2'b10, "fault");
      u_pipe.exch(1'b1);
      @(negedge ref_clk_i);
      chk(state_bit_o, 1'b1, "branch set");
      u_pipe.pulse(0);
      @(negedge ref_clk_i);
      chk(invalid_state_fault_o, 1'b0, "no fault");
      u_pipe.exch(1'b0);
      @(negedge ref_clk_i);
      chk(state_bit_o, 1'b0, "branch clear");
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      u_pipe.exch(1'b1);
      @(negedge ref_clk_i);
      chk(state_bit_o, 1'b0, "frozen bit");
      @(posedge ref_clk_i);
      ce_i <= 1'b1;
      apb(1'b1, `EESF_OFS_CTRL, 32'h1);
      u_pipe.pulse(0);
      @(negedge ref_clk_i);
      chk(lockup_o, 1'b1, "lockup");
      apb(1'b0, `EESF_OFS_STAT, 32'h0);
      chk(rd, 32'h0000_0001, "status word");
      apb(1'b0, `EESF_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0001, "control word");
      $display("state bit done");
      end_of_test();
   end
endmodule
